/* src/pwps_main.v */
// prom word program sequencer top
`include "pwps_consts.vh"
module pwps_main #(
    parameter TICK_CYC = `PWPS_TICK_CYC
) (
    input wire CORE_CLK,
    input wire RST,
    input wire [9:0] ADDR_SWITCH,
    input wire [7:0] BIT_SWITCH,
    input wire PROGRAM_BUTTON,
    input wire [1:0] BOARD_SELECT,
    input wire [7:0] BIT_OUTPUTS,
    output reg [9:0] WORD_ADDRESS_LINES,
    output reg SELECT_LOW_FIRST,
    output reg SELECT_LOW_SECOND,
    output reg SELECT_HIGH_FIRST,
    output reg SELECT_HIGH_SECOND,
    output reg [3:0] BOARD_SELECT_LOW_N,
    output reg DECODER_HIGH_LEVEL,
    output reg [7:0] PULSE_DRIVE,
    output reg [7:0] INDICATOR,
    output reg [7:0] VERIFY_DATA,
    output reg VERIFY_STROBE,
    output reg RUN
);
    wire tick;
    reg [7:0] out_sync1;
    reg [7:0] out_sync2;
    reg btn_sync1;
    reg btn_sync2;
    reg [9:0] addr_sync1;
    reg [9:0] addr_sync2;
    reg [7:0] sw_sync1;
    reg [7:0] sw_sync2;
    reg [1:0] bsel_sync1;
    reg [1:0] bsel_sync2;
    reg armed;
    reg debounced;
    reg [3:0] db_count;
    reg [3:0] time_state;
    reg [3:0] bit_state;
    reg [7:0] bit_line;
    reg [7:0] next_drive;
    integer i;

    pwps_tick #(.TICK_CYC(TICK_CYC)) u_tick (
        .core_clk(CORE_CLK),
        .rst(RST),
        .tick(tick)
    );

    // pins from outside pass two flip-flops first
    // panel switches too; moving one during a run is not supported
    always @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            out_sync1 <= 8'hFF;
            out_sync2 <= 8'hFF;
            btn_sync1 <= 1'b0;
            btn_sync2 <= 1'b0;
            addr_sync1 <= 10'h000;
            addr_sync2 <= 10'h000;
            sw_sync1 <= 8'h00;
            sw_sync2 <= 8'h00;
            bsel_sync1 <= 2'h0;
            bsel_sync2 <= 2'h0;
        end
        else
        begin
            out_sync1 <= BIT_OUTPUTS;
            out_sync2 <= out_sync1;
            btn_sync1 <= PROGRAM_BUTTON;
            btn_sync2 <= btn_sync1;
            addr_sync1 <= ADDR_SWITCH;
            addr_sync2 <= addr_sync1;
            sw_sync1 <= BIT_SWITCH;
            sw_sync2 <= sw_sync1;
            bsel_sync1 <= BOARD_SELECT;
            bsel_sync2 <= bsel_sync1;
        end
    end

    // debounce: level must hold for several ticks before it is taken
    always @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            debounced <= 1'b0;
            db_count <= 4'h0;
        end
        else if (tick)
        begin
            if (btn_sync2 == debounced)
                db_count <= 4'h0;
            else if (db_count == `PWPS_DEBOUNCE_TICKS - 4'h1)
            begin
                debounced <= btn_sync2;
                db_count <= 4'h0;
            end
            else
                db_count <= db_count + 4'h1;
        end
    end

    // one-hot bit decode, bit 8 is past the last bit
    always @*
    begin
        bit_line = 8'h00;
        for (i = 0; i < 8; i = i + 1)
            if (bit_state == i[3:0])
                bit_line[i] = 1'b1;
    end

    // pulse slot only; bit switch gates which outputs receive it
    always @*
    begin
        next_drive = 8'h00;
        if (RUN && time_state >= `PWPS_PULSE_FIRST &&
            time_state <= `PWPS_PULSE_LAST)
            next_drive = bit_line & sw_sync2;
    end

    // run flip-flop and counters; all step on the 1.0 ms tick
    // presets hold while idle so every run starts from time 5
    always @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            RUN <= 1'b0;
            time_state <= `PWPS_TIME_PRESET;
            bit_state <= `PWPS_BIT_PRESET;
            PULSE_DRIVE <= 8'h00;
            VERIFY_STROBE <= 1'b0;
            VERIFY_DATA <= 8'hFF;
        end
        else
        begin
            VERIFY_STROBE <= 1'b0;
            if (tick)
            begin
                PULSE_DRIVE <= next_drive;
                if (!RUN)
                begin
                    time_state <= `PWPS_TIME_PRESET;
                    bit_state <= `PWPS_BIT_PRESET;
                    // start only on a settled press not yet used
                    if (debounced && btn_sync2 && db_count == 4'h0 &&
                        !VERIFY_STROBE && PULSE_DRIVE == 8'h00 &&
                        !armed)
                    begin
                        RUN <= 1'b1;
                        bit_state <= 4'h0;
                    end
                end
                else
                begin
                    time_state <= time_state + 4'h1;
                    if (time_state == `PWPS_TIME_STEP_FROM)
                        bit_state <= bit_state + 4'h1;
                    // sense at the tick closing state 10; a tick of four
                    // or more cycles lets the synchronised outputs settle
                    if (time_state == `PWPS_SENSE_STATE)
                    begin
                        VERIFY_DATA <= out_sync2;
                        VERIFY_STROBE <= 1'b1;
                    end
                    if (time_state == `PWPS_TIME_LAST &&
                        bit_state == 4'h7)
                    begin
                        RUN <= 1'b0;
                        time_state <= `PWPS_TIME_PRESET;
                        bit_state <= `PWPS_BIT_PRESET;
                    end
                    else if (time_state == `PWPS_TIME_LAST)
                        time_state <= 4'h0;
                end
            end
        end
    end

    // one run per press: a held button cannot start a second run
    // the run sets the flag; set wins over the release clear
    always @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
            armed <= 1'b0;
        else if (tick && RUN)
            armed <= 1'b1;
        else if (tick && !debounced)
            armed <= 1'b0;
    end

    // pins: address, selects, board decoder, indicators
    always @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            WORD_ADDRESS_LINES <= 10'h000;
            SELECT_LOW_FIRST <= 1'b0;
            SELECT_LOW_SECOND <= 1'b0;
            SELECT_HIGH_FIRST <= 1'b1;
            SELECT_HIGH_SECOND <= 1'b1;
            BOARD_SELECT_LOW_N <= 4'hF;
            DECODER_HIGH_LEVEL <= 1'b0;
            INDICATOR <= 8'hFF;
        end
        else
        begin
            WORD_ADDRESS_LINES <= addr_sync2;
            // run deselects outputs except in the sense slot
            SELECT_LOW_FIRST <= RUN &&
                time_state != `PWPS_SENSE_STATE;
            SELECT_LOW_SECOND <= 1'b0;
            SELECT_HIGH_FIRST <= 1'b1;
            SELECT_HIGH_SECOND <= 1'b1;
            BOARD_SELECT_LOW_N <= ~(4'h1 << bsel_sync2);
            DECODER_HIGH_LEVEL <= RUN &&
                time_state != `PWPS_SENSE_STATE;
            // deselected outputs float high, so indicator lights
            INDICATOR <= (RUN ? 8'hFF : out_sync2);
        end
    end
endmodule // pwps_main

/* src/pwps_consts.vh */
// constants for the prom word program sequencer
// Operation
// - program eight bits of switch-set word
// - idle: select prom, show addressed word
// - indicator lit on one or deselected
// - sequencer stepped by 1.0 ms time base
// - debounced button sets run flip-flop
// - run enables counters, deselects prom outputs
// - idle presets: timing 5, bit 8
// - timing states place pulse in slot
// - bit counter advances on timing 3 to 4
// - after last bit reload, clear run
// - decoded bit ANDed with bit switch drives pulse
// - board: decoder drives each part's first select
// - two-bit decoder address picks target part
// - drop pulse, normal levels, sense, repeat
// - pulse one output at a time
// - at most one pulse per bit per run
`ifndef PWPS_CONSTS_VH
`define PWPS_CONSTS_VH
`define PWPS_CLK_HZ 125000000
`define PWPS_TICK_US 1000
`define PWPS_TICK_CYC ((`PWPS_CLK_HZ / 1000000) * `PWPS_TICK_US)
`define PWPS_TIME_PRESET 4'h5
`define PWPS_BIT_PRESET 4'h8
`define PWPS_TIME_STEP_FROM 4'h3
`define PWPS_TIME_LAST 4'hF
`define PWPS_PULSE_FIRST 4'h7
`define PWPS_PULSE_LAST 4'h7
`define PWPS_SENSE_STATE 4'hA
`define PWPS_DEBOUNCE_TICKS 4'h4
`endif

/* src/pwps_tick.v */
// free-running time base, one-cycle enable each period
`include "pwps_consts.vh"
module pwps_tick #(
    parameter TICK_CYC = `PWPS_TICK_CYC
) (
    input wire core_clk,
    input wire rst,
    output reg tick
);
    reg [31:0] count;
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            count <= 32'h0000_0000;
            tick <= 1'b0;
        end
        else if (count == TICK_CYC - 1)
        begin
            count <= 32'h0000_0000;
            tick <= 1'b1;
        end
        else
        begin
            count <= count + 32'h0000_0001;
            tick <= 1'b0;
        end
    end
endmodule // pwps_tick

/* sim/pwps_main_properties.sv */
// concurrent checks on the sequencer top ports
module pwps_main_properties #(
    parameter int TICK_CYC = 4
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic [7:0] BIT_SWITCH,
    input wire logic [7:0] PULSE_DRIVE,
    input wire logic [7:0] INDICATOR,
    input wire logic SELECT_LOW_FIRST,
    input wire logic SELECT_LOW_SECOND,
    input wire logic SELECT_HIGH_FIRST,
    input wire logic SELECT_HIGH_SECOND,
    input wire logic DECODER_HIGH_LEVEL,
    input wire logic VERIFY_STROBE,
    input wire logic RUN
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    // counts pulse cycles so the width check needs no long repetition
    int cnt;
    always @(posedge CORE_CLK or posedge RST)
        cnt <= RST ? 0 : ((|PULSE_DRIVE) ? cnt + 1 : 0);
    AST_ONE_PULSE: assert property ($onehot0(PULSE_DRIVE))
        else $error("pulse on several outputs");
    AST_PULSE_IN_RUN: assert property (|PULSE_DRIVE |->
        RUN && SELECT_LOW_FIRST && DECODER_HIGH_LEVEL)
        else $error("pulse outside run or with prom enabled");
    AST_PULSE_SWITCH: assert property (
        (PULSE_DRIVE & ~BIT_SWITCH) == 8'h00)
        else $error("pulse on a bit whose switch is off");
    AST_SENSE: assert property (VERIFY_STROBE |-> !SELECT_LOW_FIRST
        && !DECODER_HIGH_LEVEL && !(|PULSE_DRIVE) ##1 !VERIFY_STROBE)
        else $error("sense without normal levels");
    AST_IDLE_SELECT: assert property (!RUN && !$past(RUN) |->
        !SELECT_LOW_FIRST) else $error("prom not selected at idle");
    AST_RUN_LIT: assert property (RUN && $past(RUN) |->
        INDICATOR == 8'hFF) else $error("indicator dark during run");
    AST_FIXED_SELECTS: assert property (!SELECT_LOW_SECOND
        && SELECT_HIGH_FIRST && SELECT_HIGH_SECOND)
        else $error("fixed selects wrong");
    AST_PULSE_WIDTH: assert property ($fell(|PULSE_DRIVE) |->
        cnt == TICK_CYC) else $error("pulse width not one tick");
    cover property ($rose(RUN));
    cover property (VERIFY_STROBE);
    cover property ($fell(RUN));
endmodule // pwps_main_properties
bind pwps_main pwps_main_properties #(.TICK_CYC(TICK_CYC))
    pwps_main_properties_i (
    .CORE_CLK(CORE_CLK),
    .RST(RST),
    .BIT_SWITCH(BIT_SWITCH),
    .PULSE_DRIVE(PULSE_DRIVE),
    .INDICATOR(INDICATOR),
    .SELECT_LOW_FIRST(SELECT_LOW_FIRST),
    .SELECT_LOW_SECOND(SELECT_LOW_SECOND),
    .SELECT_HIGH_FIRST(SELECT_HIGH_FIRST),
    .SELECT_HIGH_SECOND(SELECT_HIGH_SECOND),
    .DECODER_HIGH_LEVEL(DECODER_HIGH_LEVEL),
    .VERIFY_STROBE(VERIFY_STROBE),
    .RUN(RUN)
);

/* sim/pwps_prom_model.sv */
// fuse prom model, one part of the or-tied board
module pwps_prom_model #(
    parameter int PART = 0
) (
    input wire logic [9:0] word_address_lines,
    input wire logic select_low_first,
    input wire logic select_low_second,
    input wire logic select_high_first,
    input wire logic select_high_second,
    input wire logic [3:0] board_select_low_n,
    input wire logic decoder_high_level,
    input wire logic [7:0] pulse_drive,
    output logic [7:0] bit_outputs
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:1023];
    logic en;
    initial foreach (mem[i]) mem[i] = 8'hFF;
    assign en = !select_low_first && !select_low_second && select_high_first
        && select_high_second && !board_select_low_n[PART];
    // open collector with pull-up: a released line reads one
    assign bit_outputs = en ? mem[word_address_lines] : 8'hFF;
    always @(pulse_drive)
        if (decoder_high_level && select_low_first && !board_select_low_n[PART])
            mem[word_address_lines] &= ~pulse_drive;
endmodule // pwps_prom_model

/* sim/pwps_main_tb.sv */
// self-checking bench for the prom word program sequencer
module pwps_main_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, btn = 0;
    logic [9:0] addr = 0, wal;
    logic [7:0] sw = 0, outs, ind, pd, vd;
    logic [7:0] outs0, outs1;
    logic [1:0] bsel = 0;
    logic [3:0] bsn;
    logic sl1, sl2, sh1, sh2, dhl, vs, run;
    int errors = 0, num_checks = 0;
    always #4 clk = ~clk;
    pwps_main #(.TICK_CYC(4)) pwps_main_i (.CORE_CLK(clk), .RST(rst),
        .ADDR_SWITCH(addr), .BIT_SWITCH(sw), .PROGRAM_BUTTON(btn),
        .BOARD_SELECT(bsel), .BIT_OUTPUTS(outs), .WORD_ADDRESS_LINES(wal),
        .SELECT_LOW_FIRST(sl1), .SELECT_LOW_SECOND(sl2),
        .SELECT_HIGH_FIRST(sh1), .SELECT_HIGH_SECOND(sh2),
        .BOARD_SELECT_LOW_N(bsn), .DECODER_HIGH_LEVEL(dhl), .PULSE_DRIVE(pd),
        .INDICATOR(ind), .VERIFY_DATA(vd), .VERIFY_STROBE(vs), .RUN(run));
    pwps_prom_model #(.PART(0)) pwps_prom_model_i (.word_address_lines(wal),
        .select_low_first(sl1), .select_low_second(sl2),
        .select_high_first(sh1), .select_high_second(sh2),
        .board_select_low_n(bsn), .decoder_high_level(dhl),
        .pulse_drive(pd), .bit_outputs(outs0));
    // second or-tied part: open collectors give the and of both words
    pwps_prom_model #(.PART(1)) pwps_prom_model_part1_i (
        .word_address_lines(wal), .select_low_first(sl1),
        .select_low_second(sl2), .select_high_first(sh1),
        .select_high_second(sh2), .board_select_low_n(bsn),
        .decoder_high_level(dhl), .pulse_drive(pd), .bit_outputs(outs1));
    assign outs = outs0 & outs1;
    task check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task print_verdict;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // idle display of a word on a chosen board part
    task t_show(input logic [9:0] a, input logic [1:0] b, input logic [7:0] e);
        @(negedge clk);
        addr = a;
        bsel = b;
        repeat (8) @(negedge clk);
        check(ind, e);
        check({run, sl1, dhl}, 0);
        check(wal, a);
        check(bsn, 4'hF ^ (4'h1 << b));
        $display("show %h done", a);
    endtask
    // one run: switches held from press until run clears
    task t_run(input logic [9:0] a, input logic [7:0] s, input logic [1:0] b,
        input logic [7:0] e, input logic [7:0] o, input int np);
        int n, cyc, pulses;
        logic prev;
        logic [7:0] m0, m1;
        n = 0;
        cyc = 0;
        pulses = 0;
        prev = 0;
        @(negedge clk);
        addr = a;
        sw = s;
        bsel = b;
        btn = 1;
        while (!run && n < 300)
        begin
            @(negedge clk);
            n++;
        end
        btn = 0;
        while (run && cyc < 2000)
        begin
            @(negedge clk);
            cyc++;
            pulses += (|pd && !prev);
            prev = |pd;
        end
        check((cyc + 2) / 4, 123);
        check(pulses, np);
        check(vd, e);
        m0 = pwps_prom_model_i.mem[a];
        m1 = pwps_prom_model_part1_i.mem[a];
        check(b == 0 ? m0 : m1, e);
        check(b == 0 ? m1 : m0, o);
        t_show(a, b, e);
        $display("run %h done", a);
    endtask
    initial
    begin
        #200us;
        errors++;
        print_verdict;
    end
    initial
    begin
        repeat (4) @(negedge clk);
        rst = 0;
        t_show(10'h3FF, 0, 8'hFF);
        t_run(10'h003, 8'hA5, 1, 8'h5A, 8'hFF, 4);
        t_run(10'h003, 8'h81, 0, 8'h7E, 8'h5A, 2);
        t_run(10'h003, 8'hFF, 0, 8'h00, 8'h5A, 8);
        t_show(10'h004, 0, 8'hFF);
        print_verdict;
    end
endmodule // pwps_main_tb
